// *** rtl/wdue_engine.sv ***
// Notes on behaviour
// - Unipolar 12-bit: code zero is zero volts, 4095 is full reference.
// - Unipolar 16-bit: code zero is zero volts, all ones is reference.
// - Bipolar 12-bit two's complement: -2048 is minus reference, 2047 plus.
// - Bipolar 16-bit two's complement: -32768 is minus reference, 32767 plus.
// - High-resolution: signed 18 bits in upper word bits, ten volt span.
// - A new sample goes out once per programmed update interval.
// - Intervals beyond 65535 us use a prescale counter as slower timebase.
// - Prescaler shared with acquisition only at identical timebase.
// - Group one and group two each have their own interval counter.
// - Either group may prescale, except group one in high-resolution mode; other group joins only at same timebase.
// - High-resolution mode: one sample clock times output and acquisition.
// - FIFO drained to converter on onboard or external update clock.
// - Output is strictly first in, first out.
// - Pause takes effect only once queued FIFO data has been output.
// - FIFO refill request level is programmable.
// - Generation may start from an external trigger.
// - While paused, samples stop and last voltage holds.
// - Resume continues from paused sample at same rate and buffer.
`timescale 1ns/100ps

module wdue_engine
   import wdue_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire wdue_cfg_type cfg,
   input wire logic start_req,
   input wire logic pause_req,
   input wire logic resume_req,
   input wire logic clear_req,
   input wire logic ext_update_in,
   input wire logic ext_trig_in,
   input wire logic acq_ps_req,
   input wire logic [INTERVAL_W-1:0] acq_ps_div,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [SAMPLE_W-1:0] wr_data,
   input wire logic [SAMPLE_W-1:0] g2_sample,
   output logic [CODE_W-1:0] dac1_code_ff,
   output logic dac1_strobe_ff,
   output logic [CODE_W-1:0] dac2_code_ff,
   output logic dac2_strobe_ff,
   output logic ai_sample_tick,
   output logic [COUNT_W-1:0] points_written_count_ff,
   output logic [COUNT_W-1:0] iterations_written_count_ff,
   output wdue_status_type status
);

   // ==========================================================
   // Code conversion
   // Output codes are offset binary, left justified in CODE_W bits;
   // the converter maps zero to the low end of its selected span.
   function automatic logic [CODE_W-1:0] conv_code(
      input logic [SAMPLE_W-1:0] s,
      input wdue_res_type res,
      input logic bip
   );
      logic [CODE_W-1:0] c;
      c = RST_CODE;
      unique case (res)
         WDUE_RES12: begin
            c = {s[CODE12_MSB] ^ bip, s[CODE12_MSB-1:0], 6'h0};
         end
         WDUE_RES16: begin
            c = {s[CODE16_MSB] ^ bip, s[CODE16_MSB-1:0], 2'h0};
         end
         WDUE_RES18: begin
            c = {~s[HIRES_MSB], s[HIRES_MSB-1:HIRES_LSB]};
         end
         default: begin
            c = RST_CODE;
         end
      endcase
      return c;
   endfunction : conv_code

   // ==========================================================
   // Microsecond timebase and edge detection
   logic [6:0] us_cnt_ff;
   logic us_tick;
   logic upd_q_ff;
   logic trig_q_ff;
   logic ext_upd_edge;
   logic ext_trig_edge;

   assign us_tick = (us_cnt_ff == US_LAST);
   assign ext_upd_edge = ext_update_in && !upd_q_ff;
   assign ext_trig_edge = ext_trig_in && !trig_q_ff;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         us_cnt_ff <= 7'h0;
      end else if (us_tick) begin
         us_cnt_ff <= 7'h0;
      end else begin
         us_cnt_ff <= us_cnt_ff + 7'h1;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         upd_q_ff <= 1'b0;
         trig_q_ff <= 1'b0;
      end else begin
         upd_q_ff <= ext_update_in;
         trig_q_ff <= ext_trig_in;
      end
   end

   // ==========================================================
   // Run control
   wdue_state_type state_ff;
   logic pause_pend_ff;
   logic fifo_empty;
   logic run_active;

   assign run_active = (state_ff == WDUE_RUN);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= WDUE_IDLE;
      end else if (clear_req) begin
         state_ff <= WDUE_IDLE;
      end else begin
         unique case (state_ff)
            WDUE_IDLE: begin
               if (start_req) begin
                  state_ff <= cfg.ext_trig_sel ? WDUE_ARMED : WDUE_RUN;
               end
            end
            WDUE_ARMED: begin
               if (ext_trig_edge) begin
                  state_ff <= WDUE_RUN;
               end
            end
            WDUE_RUN: begin
               if (pause_pend_ff && fifo_empty) begin
                  state_ff <= WDUE_PAUSED;
               end
            end
            WDUE_PAUSED: begin
               if (resume_req) begin
                  state_ff <= WDUE_RUN;
               end
            end
            default: begin
               state_ff <= WDUE_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pause_pend_ff <= 1'b0;
      end else if (clear_req || state_ff != WDUE_RUN) begin
         pause_pend_ff <= 1'b0;
      end else if (pause_req) begin
         pause_pend_ff <= 1'b1;
      end
   end

   // ==========================================================
   // Shared prescale counter ownership
   // A user joins only when the prescaler is free or already runs at
   // its divisor; a mismatch is flagged and that user stalls.
   logic [PS_USERS-1:0] ps_req;
   logic [INTERVAL_W-1:0] ps_want [PS_USERS];
   logic [PS_USERS-1:0] ps_owner_ff;
   logic [PS_USERS-1:0] ps_conflict;
   logic [INTERVAL_W-1:0] ps_div_ff;
   logic ps_tick;

   assign ps_req[PS_ACQ] = acq_ps_req;
   assign ps_req[PS_G1] = cfg.ps_en1 && run_active && cfg.res != WDUE_RES18;
   assign ps_req[PS_G2] = cfg.ps_en2 && run_active;
   assign ps_want[PS_ACQ] = acq_ps_div;
   assign ps_want[PS_G1] = cfg.ps_div;
   assign ps_want[PS_G2] = cfg.ps_div;

   for (genvar u = 0; u < PS_USERS; u++) begin : g_ps_user
      assign ps_conflict[u] = ps_req[u] && !ps_owner_ff[u] && (ps_owner_ff != '0)
                              && (ps_want[u] != ps_div_ff);
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ps_owner_ff <= '0;
         ps_div_ff <= RST_DIV;
      end else if (ps_owner_ff == '0) begin
         // Lowest index wins when several claim a free prescaler
         ps_owner_ff <= ps_req & (~ps_req + 3'h1);
         for (int i = PS_USERS - 1; i >= 0; i--) begin
            if (ps_req[i]) begin
               ps_div_ff <= ps_want[i];
            end
         end
      end else begin
         ps_owner_ff <= ps_req & (ps_owner_ff | ~ps_conflict);
      end
   end

   wdue_interval_counter u_prescale (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clr(ps_owner_ff == '0),
      .en(us_tick),
      .period(ps_div_ff),
      .tick(ps_tick)
   );

   // ==========================================================
   // Group update interval counters
   logic g1_en;
   logic g2_en;
   logic g1_cnt_tick;
   logic g2_cnt_tick;
   logic g1_tick;

   assign g1_en = run_active && (ps_req[PS_G1] ? (ps_tick && ps_owner_ff[PS_G1]) : us_tick);
   assign g2_en = run_active && (ps_req[PS_G2] ? (ps_tick && ps_owner_ff[PS_G2]) : us_tick);
   assign g1_tick = cfg.ext_clk_sel ? (run_active && ext_upd_edge) : g1_cnt_tick;
   assign ai_sample_tick = (cfg.res == WDUE_RES18) && g1_tick;

   wdue_interval_counter u_update_interval_counter1 (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clr(!(run_active || state_ff == WDUE_PAUSED) || clear_req),
      .en(g1_en),
      .period(cfg.interval1),
      .tick(g1_cnt_tick)
   );

   wdue_interval_counter u_update_interval_counter2 (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clr(!(run_active || state_ff == WDUE_PAUSED) || clear_req),
      .en(g2_en),
      .period(cfg.interval2),
      .tick(g2_cnt_tick)
   );

   // ==========================================================
   // Group one FIFO
   logic [SAMPLE_W-1:0] fifo_mem [FIFO_DEPTH];
   logic [FIFO_AW-1:0] wr_ptr_ff;
   logic [FIFO_AW-1:0] rd_ptr_ff;
   logic [FIFO_AW:0] level_ff;
   logic fifo_full;
   logic push;
   logic pop;

   assign fifo_empty = (level_ff == '0);
   assign fifo_full = (level_ff == 5'(FIFO_DEPTH));
   assign wr_ready = !fifo_full && !clear_req;
   assign push = wr_valid && wr_ready;
   assign pop = g1_tick && !fifo_empty && !clear_req;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         fifo_mem[wr_ptr_ff] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         level_ff <= '0;
      end else if (clear_req) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         level_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 4'h1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 4'h1;
         end
         level_ff <= level_ff + 5'(push) - 5'(pop);
      end
   end

   // ==========================================================
   // Converter outputs
   // Codes only change on an update; pause freezes the counters so the
   // last voltage holds without any extra register.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         dac1_code_ff <= RST_CODE;
         dac1_strobe_ff <= 1'b0;
      end else begin
         dac1_strobe_ff <= pop;
         if (pop) begin
            dac1_code_ff <= conv_code(fifo_mem[rd_ptr_ff], cfg.res, cfg.bipolar);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         dac2_code_ff <= RST_CODE;
         dac2_strobe_ff <= 1'b0;
      end else begin
         dac2_strobe_ff <= g2_cnt_tick;
         if (g2_cnt_tick) begin
            dac2_code_ff <= conv_code(g2_sample, cfg.res, cfg.bipolar);
         end
      end
   end

   // ==========================================================
   // Progress counts follow FIFO writes, so they lead the analog output
   logic [INTERVAL_W-1:0] pos_ff;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pos_ff <= RST_DIV;
         points_written_count_ff <= RST_COUNT;
         iterations_written_count_ff <= RST_COUNT;
      end else if (clear_req) begin
         pos_ff <= RST_DIV;
         points_written_count_ff <= RST_COUNT;
         iterations_written_count_ff <= RST_COUNT;
      end else if (push) begin
         points_written_count_ff <= points_written_count_ff + 32'h1;
         if (pos_ff + 16'h1 >= cfg.buf_len) begin
            pos_ff <= RST_DIV;
            iterations_written_count_ff <= iterations_written_count_ff + 32'h1;
         end else begin
            pos_ff <= pos_ff + 16'h1;
         end
      end
   end

   // ==========================================================
   // Status
   always_comb begin
      status = '0;
      status.running = run_active;
      status.paused = (state_ff == WDUE_PAUSED);
      status.pause_pending = pause_pend_ff;
      status.fifo_empty = fifo_empty;
      status.fifo_full = fifo_full;
      status.refill_req = (level_ff <= cfg.refill_level);
      status.ps_owner = ps_owner_ff;
      status.ps_conflict = ps_conflict;
   end

   // ==========================================================
   // Assertions
   property p_full_refuses;
      @(posedge clk_sys) disable iff (sys_rst)
      fifo_full |-> !wr_ready ##1 (level_ff <= 5'(FIFO_DEPTH));
   endproperty
   a_full_refuses: assert property (p_full_refuses) else $error("write taken while full");

   property p_clear_flush;
      @(posedge clk_sys) disable iff (sys_rst)
      clear_req |=> fifo_empty && points_written_count_ff == '0 && state_ff == WDUE_IDLE;
   endproperty
   a_clear_flush: assert property (p_clear_flush) else $error("clear left state behind");

   property p_points_follow_writes;
      @(posedge clk_sys) disable iff (sys_rst)
      push && !clear_req |=> points_written_count_ff == $past(points_written_count_ff) + 32'h1;
   endproperty
   a_points_follow_writes: assert property (p_points_follow_writes) else $error("count missed write");

   property p_pause_waits;
      @(posedge clk_sys) disable iff (sys_rst)
      run_active && !fifo_empty |=> state_ff != WDUE_PAUSED;
   endproperty
   a_pause_waits: assert property (p_pause_waits) else $error("paused with data queued");

   property p_pause_holds;
      @(posedge clk_sys) disable iff (sys_rst)
      state_ff == WDUE_PAUSED ##1 state_ff == WDUE_PAUSED |-> $stable(dac1_code_ff) && !dac1_strobe_ff;
   endproperty
   a_pause_holds: assert property (p_pause_holds) else $error("output moved while paused");

   property p_code_order;
      @(posedge clk_sys) disable iff (sys_rst)
      pop ##1 !$changed(cfg) |-> dac1_code_ff == conv_code($past(fifo_mem[rd_ptr_ff]), cfg.res, cfg.bipolar);
   endproperty
   a_code_order: assert property (p_code_order) else $error("wrong code at converter");

   property p_update_spacing;
      @(posedge clk_sys) disable iff (sys_rst)
      g1_cnt_tick && !cfg.ext_clk_sel |=> !g1_cnt_tick [*8];
   endproperty
   a_update_spacing: assert property (p_update_spacing) else $error("updates too close");

   property p_prescale_share;
      @(posedge clk_sys) disable iff (sys_rst)
      ps_owner_ff[PS_ACQ] && ps_owner_ff[PS_G1] |-> acq_ps_div == cfg.ps_div;
   endproperty
   a_prescale_share: assert property (p_prescale_share) else $error("prescaler shared at two rates");

   property p_trigger_start;
      @(posedge clk_sys) disable iff (sys_rst)
      state_ff == WDUE_ARMED && ext_trig_edge && !clear_req |=> run_active;
   endproperty
   a_trigger_start: assert property (p_trigger_start) else $error("trigger did not start");

endmodule : wdue_engine

// *** rtl/wdue_pkg.sv ***
package wdue_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);

   // ==========================================================
   // Widths and depths
   localparam int SAMPLE_W = 32;
   localparam int CODE_W = 18;
   localparam int INTERVAL_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   localparam int COUNT_W = 32;
   localparam logic [INTERVAL_W-1:0] INTERVAL_RANGE_US = 16'hffff;

   // ==========================================================
   // Field positions
   localparam int CODE12_MSB = 11;
   localparam int CODE16_MSB = 15;
   localparam int HIRES_LSB = 14;
   localparam int HIRES_MSB = 31;

   // ==========================================================
   // Reset values
   localparam logic [CODE_W-1:0] RST_CODE = 18'h0;
   localparam logic [COUNT_W-1:0] RST_COUNT = 32'h0;
   localparam logic [INTERVAL_W-1:0] RST_DIV = 16'h0;

   // ==========================================================
   // Prescale users
   localparam int PS_USERS = 3;
   localparam int PS_ACQ = 0;
   localparam int PS_G1 = 1;
   localparam int PS_G2 = 2;

   typedef enum logic [1:0] {
      WDUE_RES12 = 2'h0,
      WDUE_RES16 = 2'h1,
      WDUE_RES18 = 2'h2
   } wdue_res_type;

   typedef enum logic [3:0] {
      WDUE_IDLE   = 4'h1,
      WDUE_ARMED  = 4'h2,
      WDUE_RUN    = 4'h4,
      WDUE_PAUSED = 4'h8
   } wdue_state_type;

   typedef struct packed {
      wdue_res_type res;
      logic bipolar;
      logic ext_clk_sel;
      logic ext_trig_sel;
      logic ps_en1;
      logic ps_en2;
      logic [INTERVAL_W-1:0] interval1;
      logic [INTERVAL_W-1:0] interval2;
      logic [INTERVAL_W-1:0] ps_div;
      logic [INTERVAL_W-1:0] buf_len;
      logic [FIFO_AW:0] refill_level;
   } wdue_cfg_type;

   typedef struct packed {
      logic running;
      logic paused;
      logic pause_pending;
      logic fifo_empty;
      logic fifo_full;
      logic refill_req;
      logic [PS_USERS-1:0] ps_owner;
      logic [PS_USERS-1:0] ps_conflict;
   } wdue_status_type;

endpackage : wdue_pkg

// *** rtl/wdue_interval_counter.sv ***
`timescale 1ns/100ps

module wdue_interval_counter
   import wdue_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clr,
   input wire logic en,
   input wire logic [INTERVAL_W-1:0] period,
   output logic tick
);

   logic [INTERVAL_W-1:0] cnt_ff;
   logic [INTERVAL_W-1:0] last_val;

   // A zero period behaves as one so the counter can never lock up
   assign last_val = (period == RST_DIV) ? RST_DIV : period - 16'h1;
   assign tick = en && !clr && (cnt_ff >= last_val);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= RST_DIV;
      end else if (clr || tick) begin
         cnt_ff <= RST_DIV;
      end else if (en) begin
         cnt_ff <= cnt_ff + 16'h1;
      end
   end

endmodule : wdue_interval_counter

// *** dv/wdue_host_model.sv ***
`timescale 1ns/100ps

// ==========================================
// Host writer: offers queued samples in order
module wdue_host_model
   import wdue_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic wr_ready,
   output logic wr_valid,
   output logic [SAMPLE_W-1:0] wr_data
);
   logic [SAMPLE_W-1:0] q[$];

   task automatic push(input logic [SAMPLE_W-1:0] w);
      q.push_back(w);
   endtask : push

   // A word stays offered until it is taken, however long the engine refuses
   always @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_valid <= 1'b0;
         wr_data <= 32'h0;
      end else if (!wr_valid || wr_ready) begin
         if (wr_valid)
            void'(q.pop_front());
         if (q.size() != 0) begin
            wr_valid <= 1'b1;
            wr_data <= q[0];
         end else begin
            wr_valid <= 1'b0;
            // Idle data toggles each cycle, alternating between the last sample and its complement
            wr_data <= ~wr_data;
         end
      end
   end
endmodule : wdue_host_model

// *** dv/waveform_dac_update_engine_tb.sv ***
`timescale 1ns/100ps

module waveform_dac_update_engine_tb
   import wdue_pkg::*;
;
   localparam int START = 0;
   localparam int PAUSE = 1;
   localparam int RESUME = 2;
   localparam int CLEAR = 3;
   localparam int UPD = 4;
   localparam int TRIG = 5;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   wdue_cfg_type cfg = '0;
   logic [5:0] rq = 6'h0;
   logic acq_ps_req = 1'b0;
   logic [INTERVAL_W-1:0] acq_ps_div = 16'h0;
   logic [SAMPLE_W-1:0] g2_sample = 32'h1234;
   logic wr_valid, wr_ready, st1, st2, ai_tick;
   logic [SAMPLE_W-1:0] wr_data;
   logic [CODE_W-1:0] c1, c2;
   logic [COUNT_W-1:0] pts, its;
   wdue_status_type status;
   logic [31:0] cyc = 0, ai_n = 0, s1_n = 0, s1_last = 0, s1_gap = 0, s1_code = 0;
   logic [31:0] s2_n = 0, s2_last = 0, s2_gap = 0, s2_code = 0;
   int n_fail = 0;
   int tests_run = 0;

   always #5 clk_sys = ~clk_sys;

   wdue_engine wdue_engine_i (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .cfg(cfg),
      .start_req(rq[START]),
      .pause_req(rq[PAUSE]),
      .resume_req(rq[RESUME]),
      .clear_req(rq[CLEAR]),
      .ext_update_in(rq[UPD]),
      .ext_trig_in(rq[TRIG]),
      .acq_ps_req(acq_ps_req),
      .acq_ps_div(acq_ps_div),
      .wr_valid(wr_valid),
      .wr_ready(wr_ready),
      .wr_data(wr_data),
      .g2_sample(g2_sample),
      .dac1_code_ff(c1),
      .dac1_strobe_ff(st1),
      .dac2_code_ff(c2),
      .dac2_strobe_ff(st2),
      .ai_sample_tick(ai_tick),
      .points_written_count_ff(pts),
      .iterations_written_count_ff(its),
      .status(status)
   );

   wdue_host_model wdue_host_model_i (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .wr_ready(wr_ready),
      .wr_valid(wr_valid),
      .wr_data(wr_data)
   );

   // ==========================================
   // Output monitor: strobe counts, spacing, codes
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (ai_tick === 1'b1)
         ai_n = ai_n + 1;
      if (st1 === 1'b1) begin
         s1_n = s1_n + 1;
         s1_gap = cyc - s1_last;
         s1_last = cyc;
         s1_code = 32'(c1);
      end
      if (st2 === 1'b1) begin
         s2_n = s2_n + 1;
         s2_gap = cyc - s2_last;
         s2_last = cyc;
         s2_code = 32'(c2);
      end
   end

   // ==========================================
   // Helpers
   task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_v

   task automatic chk_f(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_f

   task automatic req(input int k);
      @(posedge clk_sys);
      rq <= 6'h1 << k;
      @(posedge clk_sys);
      rq <= 6'h0;
      #1;
   endtask : req

   task automatic wait_s1(input logic [31:0] n);
      for (int k = 0; k < 3000 && s1_n < n; k++)
         @(posedge clk_sys);
      #1;
      chk_v(s1_n, n);
   endtask : wait_s1

   task automatic drain();
      for (int k = 0; k < 60 && wdue_host_model_i.q.size() != 0; k++)
         @(posedge clk_sys);
      @(posedge clk_sys);
      #1;
   endtask : drain

   task automatic fresh(input wdue_res_type r, input logic b, input logic [1:0] m);
      req(CLEAR);
      @(posedge clk_sys);
      acq_ps_req <= 1'b0;
      cfg <= '{res: r, bipolar: b, ext_clk_sel: m[0], ext_trig_sel: m[1], interval1: 16'h3,
               interval2: 16'h2, ps_div: 16'h2, buf_len: 16'h2, refill_level: 5'h2, default: '0};
   endtask : fresh

   // ==========================================
   // Scenarios
   task automatic t_reset();
      chk_v(32'(c1), 32'h0);
      chk_v(pts, 32'h0);
      chk_f(status.fifo_empty, 1'b1);
   endtask : t_reset

   task automatic t_codes();
      logic [31:0] n;
      logic [2:0] mb[9] = '{3'h0, 3'h0, 3'h2, 3'h1, 3'h1, 3'h3, 3'h3, 3'h4, 3'h4};
      logic [31:0] dv[9] = '{32'h0, 32'hfff, 32'hffff, 32'h800, 32'h7ff, 32'h8000, 32'h7fff,
                             32'h80000000, 32'h7fffc000};
      logic [31:0] ev[9] = '{32'h0, 32'h3ffc0, 32'h3fffc, 32'h0, 32'h3ffc0, 32'h0, 32'h3fffc,
                             32'h0, 32'h3ffff};
      for (int i = 0; i < 9; i++) begin
         fresh(wdue_res_type'(mb[i][2:1]), mb[i][0], 2'h1);
         wdue_host_model_i.push(dv[i]);
         drain();
         req(START);
         n = s1_n + 1;
         req(UPD);
         wait_s1(n);
         chk_v(s1_code, ev[i]);
      end
      chk_v(ai_n, 32'h2);
   endtask : t_codes

   task automatic t_pause();
      logic [31:0] n;
      fresh(WDUE_RES16, 1'b0, 2'h1);
      for (int i = 1; i < 4; i++)
         wdue_host_model_i.push(32'h1111 * i);
      drain();
      req(START);
      req(PAUSE);
      chk_f(status.pause_pending, 1'b1);
      chk_f(status.paused, 1'b0);
      for (int i = 1; i < 4; i++) begin
         n = s1_n + 1;
         req(UPD);
         wait_s1(n);
         chk_v(s1_code, 32'h4444 * i);
      end
      @(posedge clk_sys);
      #1;
      chk_f(status.paused, 1'b1);
      req(UPD);
      repeat (3) @(posedge clk_sys);
      #1;
      chk_v(s1_n, n);
      chk_v(32'(c1), 32'h0cccc);
      req(RESUME);
      chk_f(status.running, 1'b1);
      chk_f(status.fifo_empty, 1'b1);
      wdue_host_model_i.push(32'h0505);
      drain();
      req(UPD);
      wait_s1(n + 1);
      chk_v(s1_code, 32'h01414);
   endtask : t_pause

   task automatic t_trig();
      logic [31:0] n;
      fresh(WDUE_RES16, 1'b0, 2'h3);
      wdue_host_model_i.push(32'h4444);
      drain();
      req(START);
      chk_f(status.running, 1'b0);
      req(TRIG);
      @(posedge clk_sys);
      #1;
      chk_f(status.running, 1'b1);
      n = s1_n + 1;
      req(UPD);
      wait_s1(n);
      chk_v(s1_code, 32'h11110);
   endtask : t_trig

   task automatic t_timing();
      fresh(WDUE_RES16, 1'b0, 2'h0);
      g2_sample <= 32'h2345;
      repeat (4) wdue_host_model_i.push(32'h0100);
      drain();
      req(START);
      wait_s1(s1_n + 3);
      chk_v(s1_gap, 32'd300);
      chk_v(s2_gap, 32'd200);
      chk_v(s2_code, 32'h08d14);
      fresh(WDUE_RES16, 1'b0, 2'h0);
      @(posedge clk_sys);
      cfg.ps_en1 <= 1'b1;
      cfg.interval1 <= 16'h2;
      // Both groups ask at one divisor, so group two must join, not stall
      cfg.ps_en2 <= 1'b1;
      repeat (4) wdue_host_model_i.push(32'h0200);
      drain();
      req(START);
      wait_s1(s1_n + 3);
      chk_v(s1_gap, 32'd400);
      chk_v(32'(status.ps_owner), 32'h6);
      chk_v(s2_gap, 32'd400);
      @(posedge clk_sys);
      acq_ps_req <= 1'b1;
      acq_ps_div <= 16'h2;
      repeat (3) @(posedge clk_sys);
      chk_v(32'(status.ps_owner), 32'h7);
      chk_v(32'(status.ps_conflict), 32'h0);
   endtask : t_timing

   task automatic t_conflict();
      logic [31:0] n;
      fresh(WDUE_RES16, 1'b0, 2'h0);
      @(posedge clk_sys);
      cfg.ps_en1 <= 1'b1;
      acq_ps_req <= 1'b1;
      acq_ps_div <= 16'h3;
      wdue_host_model_i.push(32'h0300);
      drain();
      req(START);
      n = s1_n;
      repeat (800) @(posedge clk_sys);
      chk_v(32'(status.ps_conflict), 32'h2);
      chk_v(s1_n, n);
   endtask : t_conflict

   task automatic t_counts();
      logic [31:0] n;
      fresh(WDUE_RES16, 1'b0, 2'h1);
      repeat (3) wdue_host_model_i.push(32'h0700);
      drain();
      chk_v(pts, 32'h3);
      chk_v(its, 32'h1);
      chk_f(status.refill_req, 1'b0);
      req(START);
      n = s1_n + 1;
      req(UPD);
      wait_s1(n);
      chk_v(pts, 32'h3);
      chk_f(status.refill_req, 1'b1);
      req(CLEAR);
      chk_f(status.fifo_empty, 1'b1);
      chk_v(pts, 32'h0);
      chk_v(its, 32'h0);
      chk_f(status.running, 1'b0);
      // Host queue holds twice the FIFO depth; only one FIFO load may be taken
      repeat (2 * FIFO_DEPTH) wdue_host_model_i.push(32'h0800);
      drain();
      chk_f(status.fifo_full, 1'b1);
      chk_f(wr_ready, 1'b0);
      chk_v(pts, 32'(FIFO_DEPTH));
   endtask : t_counts

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      #1;
      t_reset();
      t_codes();
      t_pause();
      t_trig();
      t_timing();
      t_conflict();
      t_counts();
      report_and_stop();
   end

   // Whole run needs under 5000 cycles; the margin covers slow stalls
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end
endmodule : waveform_dac_update_engine_tb
